//--- src/sysclk_pkg.sv
// constants for the system clock and operating mode controller
// assumes one 50 MHz bus clock; oscillators are analog and sit outside
package sysclk_pkg;
	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_SYSCLK_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_FAST_OSC_CTRL   = 8'h04;
	localparam logic [7:0] ADDR_CRYSTAL_OSC_CTRL = 8'h08;
	localparam logic [7:0] ADDR_PERIPH_CTRL     = 8'h0c;
	localparam logic [7:0] ADDR_MODE_STATUS     = 8'h10;
	// ------------------------------------------------------------
	// sysclk_ctrl fields
	// ------------------------------------------------------------
	localparam int SEL_LSB      = 5;
	localparam int WDT_SRC_BIT  = 4;
	localparam int SLOW_SRC_BIT = 2;
	localparam int FAST_KA_BIT  = 1;
	localparam int SLOW_KA_BIT  = 0;
	localparam logic [2:0] SEL_SLOW = 3'h7;
	localparam logic [7:0] SYSCLK_CTRL_RST = 8'h00;
	// ------------------------------------------------------------
	// oscillator control fields
	// ------------------------------------------------------------
	localparam int FREQ_LSB   = 2;
	localparam int STABLE_BIT = 1;
	localparam int EN_BIT     = 0;
	localparam logic [1:0] FREQ_8M  = 2'h0;
	localparam logic [1:0] FREQ_12M = 2'h1;
	localparam logic [1:0] FREQ_16M = 2'h2;
	localparam logic [1:0] DRV_LOW_POWER   = 2'h0;
	localparam logic [1:0] DRV_QUICK_START = 2'h1;
	localparam logic [3:0] FAST_OSC_CTRL_RST    = 4'h1;
	localparam logic [3:0] CRYSTAL_OSC_CTRL_RST = 4'h0;
	// peripheral enable bits: lcd, timebase, watchdog, lcd source, timebase source, pin release
	localparam int LCD_EN_BIT  = 0;
	localparam int TB_EN_BIT   = 1;
	localparam int WDT_EN_BIT  = 2;
	localparam int LCD_SRC_BIT = 3;
	localparam int TB_SRC_BIT  = 4;
	localparam int PIO_BIT     = 5;
	// ------------------------------------------------------------
	// timing: bus clock rate, oscillator start-up and clock switch sync figures
	// ------------------------------------------------------------
	localparam int CLK_MHZ         = 50;
	localparam int FAST_START_US   = 16;
	localparam int XTAL_QUICK_MS   = 1;
	localparam int XTAL_LOWPWR_MS  = 2;
	localparam int FAST_START_CYC  = FAST_START_US * CLK_MHZ;
	localparam int XTAL_QUICK_CYC  = XTAL_QUICK_MS * 1000 * CLK_MHZ;
	localparam int XTAL_LOWPWR_CYC = XTAL_LOWPWR_MS * 1000 * CLK_MHZ;
	localparam int SWITCH_SYNC_CYC = 4;
	// ------------------------------------------------------------
	// operating modes
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		MODE_FAST           = 6'h01,
		MODE_SLOW           = 6'h02,
		MODE_SLEEP          = 6'h04,
		MODE_IDLE_SLOW_ONLY = 6'h08,
		MODE_IDLE_BOTH_OSC  = 6'h10,
		MODE_IDLE_FAST_ONLY = 6'h20
	} op_mode_t;
endpackage

//--- src/sysclk_mode_ctrl.sv
// system clock source selection, oscillator enables and halt mode decode
// assumes apb master on pclk; oscillator stability comes from timers here
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/10ps
module sysclk_mode_ctrl #(
	parameter int XTAL_QUICK_CYCLES  = sysclk_pkg::XTAL_QUICK_CYC,
	parameter int XTAL_LOWPWR_CYCLES = sysclk_pkg::XTAL_LOWPWR_CYC,
	parameter int DIV_WIDTH          = 6
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        halt_req,
	input  wire logic        wakeup,
	output logic             cpu_run,
	output logic             fast_osc_on,
	output logic [1:0]       fast_freq_sel,
	output logic             slow_rc_osc_on,
	output logic             crystal_osc_on,
	output logic [1:0]       crystal_drive_mode,
	output logic             crystal_pins_gpio,
	output logic [2:0]       sysclk_sel_active,
	output logic             sysclk_tick,
	output logic             slow_clk_periph_on,
	output logic             lcd_clk_on,
	output logic             timebase_clk_on,
	output logic             watchdog_clk_on
);
	// divider is sized for the /64 ratio; crystal counts must fit their counter
	initial begin
		if (DIV_WIDTH != 6 || XTAL_QUICK_CYCLES < 1 || XTAL_LOWPWR_CYCLES < XTAL_QUICK_CYCLES)
			$error("sysclk_mode_ctrl: unsupported parameters");
		if (XTAL_LOWPWR_CYCLES >= (1 << 24))
			$error("sysclk_mode_ctrl: crystal start-up count exceeds its counter");
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0]  sysclk_ctrl_reg;
	logic [3:0]  fast_osc_ctrl_reg;
	logic [3:0]  crystal_osc_ctrl_reg;
	logic [5:0]  periph_ctrl_reg;
	sysclk_pkg::op_mode_t mode_reg;
	logic [2:0]  sel_active_reg;
	logic [2:0]  sel_pending_reg;
	logic [2:0]  switch_cnt_reg;
	logic [15:0] fast_cnt_reg;
	logic [23:0] xtal_cnt_reg;
	logic        fast_stable_reg;
	logic        xtal_stable_reg;
	logic [DIV_WIDTH-1:0] div_cnt_reg;
	logic        tick_reg;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire wr_en     = psel && penable && pwrite && clk_en;
	wire wr_sysclk = wr_en && paddr == sysclk_pkg::ADDR_SYSCLK_CTRL;
	wire wr_fast   = wr_en && paddr == sysclk_pkg::ADDR_FAST_OSC_CTRL;
	wire wr_xtal   = wr_en && paddr == sysclk_pkg::ADDR_CRYSTAL_OSC_CTRL;
	wire wr_periph = wr_en && paddr == sysclk_pkg::ADDR_PERIPH_CTRL;
	wire addr_ok   = paddr == sysclk_pkg::ADDR_SYSCLK_CTRL
		|| paddr == sysclk_pkg::ADDR_FAST_OSC_CTRL
		|| paddr == sysclk_pkg::ADDR_CRYSTAL_OSC_CTRL
		|| paddr == sysclk_pkg::ADDR_PERIPH_CTRL
		|| paddr == sysclk_pkg::ADDR_MODE_STATUS;

	wire [2:0] sel_req   = sysclk_ctrl_reg[sysclk_pkg::SEL_LSB +: 3];
	wire       slow_src  = sysclk_ctrl_reg[sysclk_pkg::SLOW_SRC_BIT];
	wire       wdt_src   = sysclk_ctrl_reg[sysclk_pkg::WDT_SRC_BIT];
	wire       fast_ka   = sysclk_ctrl_reg[sysclk_pkg::FAST_KA_BIT];
	wire       slow_ka   = sysclk_ctrl_reg[sysclk_pkg::SLOW_KA_BIT];
	wire       fast_en   = fast_osc_ctrl_reg[sysclk_pkg::EN_BIT];
	wire [1:0] fast_freq = fast_osc_ctrl_reg[sysclk_pkg::FREQ_LSB +: 2];
	wire       xtal_en   = crystal_osc_ctrl_reg[sysclk_pkg::EN_BIT];
	wire [1:0] xtal_drv  = crystal_osc_ctrl_reg[sysclk_pkg::FREQ_LSB +: 2];
	wire       lcd_en    = periph_ctrl_reg[sysclk_pkg::LCD_EN_BIT];
	wire       tb_en     = periph_ctrl_reg[sysclk_pkg::TB_EN_BIT];
	wire       wdt_en    = periph_ctrl_reg[sysclk_pkg::WDT_EN_BIT];
	wire       lcd_src   = periph_ctrl_reg[sysclk_pkg::LCD_SRC_BIT];
	wire       tb_src    = periph_ctrl_reg[sysclk_pkg::TB_SRC_BIT];
	wire       pio_req   = periph_ctrl_reg[sysclk_pkg::PIO_BIT];

	// halted modes where low-speed oscillators only serve the 32k users
	wire halted    = mode_reg != sysclk_pkg::MODE_FAST && mode_reg != sysclk_pkg::MODE_SLOW;
	wire cut_modes = mode_reg == sysclk_pkg::MODE_SLEEP
		|| mode_reg == sysclk_pkg::MODE_IDLE_FAST_ONLY;
	wire rc_need   = (lcd_en && !lcd_src) || (tb_en && !tb_src) || (wdt_en && !wdt_src);
	wire xt_need   = (lcd_en && lcd_src) || (tb_en && tb_src) || (wdt_en && wdt_src);
	wire slow_sys  = sel_active_reg == sysclk_pkg::SEL_SLOW;

	// crystal drives sysclk, drive mode locked
	wire xtal_is_sys = slow_sys && slow_src && xtal_stable_reg;

	// fast oscillator follows enable unless idled away
	wire fast_run = fast_en && !(halted && !fast_ka);
	wire slow_ka_live = !halted || mode_reg == sysclk_pkg::MODE_IDLE_SLOW_ONLY
		|| mode_reg == sysclk_pkg::MODE_IDLE_BOTH_OSC;
	wire rc_run   = cut_modes ? rc_need : ((slow_ka_live && !slow_src) || rc_need);
	// crystal runs whenever enabled, except in sleep or fast-only
	// idle where only a 32k user keeps it alive; its start-up then restarts
	wire xt_run   = xtal_en && (!cut_modes || xt_need);

	wire tgt_stable = (sel_pending_reg == sysclk_pkg::SEL_SLOW)
		? (slow_src ? xtal_stable_reg : 1'b1) : fast_stable_reg;

	// start-up length by drive mode, low power is longest
	wire [23:0] xtal_limit = (xtal_drv == sysclk_pkg::DRV_LOW_POWER)
		? 24'(XTAL_LOWPWR_CYCLES) : 24'(XTAL_QUICK_CYCLES);

	// divider terminal count per select code
	function automatic logic [DIV_WIDTH-1:0] div_max(input logic [2:0] sel);
		// slow select wraps every cycle so a hand-over out of slow mode is never blocked
		div_max = (sel == sysclk_pkg::SEL_SLOW) ? '0 : DIV_WIDTH'((7'h01 << sel) - 7'h01);
	endfunction
	wire div_wrap = div_cnt_reg >= div_max(sel_active_reg);

	sysclk_pkg::op_mode_t halt_mode;
	assign halt_mode = (!fast_ka && !slow_ka) ? sysclk_pkg::MODE_SLEEP
		: (!fast_ka) ? sysclk_pkg::MODE_IDLE_SLOW_ONLY
		: (slow_ka) ? sysclk_pkg::MODE_IDLE_BOTH_OSC
		: sysclk_pkg::MODE_IDLE_FAST_ONLY;
	wire sysclk_mode_is_slow = slow_sys;
	sysclk_pkg::op_mode_t run_mode;
	assign run_mode = sysclk_mode_is_slow ? sysclk_pkg::MODE_SLOW : sysclk_pkg::MODE_FAST;

	// read mux
	logic [31:0] rd_data;
	assign rd_data = (paddr == sysclk_pkg::ADDR_SYSCLK_CTRL) ? {24'h0, sysclk_ctrl_reg}
		: (paddr == sysclk_pkg::ADDR_FAST_OSC_CTRL)
			? {28'h0, fast_osc_ctrl_reg[3:2], fast_stable_reg, fast_osc_ctrl_reg[0]}
		: (paddr == sysclk_pkg::ADDR_CRYSTAL_OSC_CTRL)
			? {28'h0, crystal_osc_ctrl_reg[3:2], xtal_stable_reg, crystal_osc_ctrl_reg[0]}
		: (paddr == sysclk_pkg::ADDR_PERIPH_CTRL) ? {26'h0, periph_ctrl_reg}
		: (paddr == sysclk_pkg::ADDR_MODE_STATUS) ? {23'h0, sel_active_reg, mode_reg}
		: 32'h0;

	// ------------------------------------------------------------
	// apb slave: zero wait states, unmapped reads zero with error
	// ------------------------------------------------------------
	// ready and error answer the setup cycle, so they stand in the access phase
	wire setup_phase = psel && !penable;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready  <= setup_phase;
			pslverr <= setup_phase && !addr_ok;
		end
	end

	// read data follows the address each cycle; only valid alongside ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (clk_en) begin
			prdata <= rd_data;
		end
	end

	// selects and keep-alives clear at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sysclk_ctrl_reg <= sysclk_pkg::SYSCLK_CTRL_RST;
		end else if (wr_sysclk) begin
			sysclk_ctrl_reg <= {pwdata[7:4], 1'b0, pwdata[2:0]};
		end
	end

	// frequency select stored, fast oscillator enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_osc_ctrl_reg <= sysclk_pkg::FAST_OSC_CTRL_RST;
		end else if (wr_fast) begin
			fast_osc_ctrl_reg <= {pwdata[3:2], 1'b0, pwdata[0]};
		end
	end

	// drive mode write, held when locked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crystal_osc_ctrl_reg <= sysclk_pkg::CRYSTAL_OSC_CTRL_RST;
		end else if (wr_xtal) begin
			crystal_osc_ctrl_reg <= {xtal_is_sys ? xtal_drv : pwdata[3:2], 1'b0, pwdata[0]};
		end
	end

	// peripheral clock enables, sources and pin release request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_ctrl_reg <= 6'h0;
		end else if (wr_periph) begin
			periph_ctrl_reg <= pwdata[5:0];
		end
	end

	// fast stable flag restarts on enable or frequency change
	wire fast_restart = wr_fast && ((pwdata[0] && !fast_en) || pwdata[3:2] != fast_freq);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_cnt_reg    <= 16'h0;
			fast_stable_reg <= 1'b0;
		end else if (clk_en) begin
			if (fast_restart || !fast_run) begin
				fast_cnt_reg    <= 16'h0;
				fast_stable_reg <= 1'b0;
			end else if (fast_cnt_reg < 16'(sysclk_pkg::FAST_START_CYC)) begin
				fast_cnt_reg <= fast_cnt_reg + 16'h1;
			end else begin
				fast_stable_reg <= 1'b1;
			end
		end
	end

	wire xtal_restart = wr_xtal && pwdata[0] && !xtal_en;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xtal_cnt_reg    <= 24'h0;
			xtal_stable_reg <= 1'b0;
		end else if (clk_en) begin
			if (xtal_restart || !xt_run) begin
				xtal_cnt_reg    <= 24'h0;
				xtal_stable_reg <= 1'b0;
			end else if (xtal_cnt_reg < xtal_limit) begin
				xtal_cnt_reg <= xtal_cnt_reg + 24'h1;
			end else begin
				xtal_stable_reg <= 1'b1;
			end
		end
	end

	// switch waits for stable target plus sync cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_active_reg  <= 3'h0;
			sel_pending_reg <= 3'h0;
			switch_cnt_reg  <= 3'h0;
		end else if (clk_en) begin
			sel_pending_reg <= sel_req;
			if (sel_pending_reg != sel_req || sel_pending_reg == sel_active_reg || !tgt_stable)
				switch_cnt_reg <= 3'h0;
			else if (switch_cnt_reg < 3'(sysclk_pkg::SWITCH_SYNC_CYC))
				switch_cnt_reg <= switch_cnt_reg + 3'h1;
			// hand over only at divider wrap so no short pulse appears
			if (switch_cnt_reg == 3'(sysclk_pkg::SWITCH_SYNC_CYC) && div_wrap)
				sel_active_reg <= sel_pending_reg;
		end
	end

	// divided fast clock as a tick, slow clock passes through
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_reg <= '0;
			tick_reg    <= 1'b0;
		end else if (clk_en) begin
			div_cnt_reg <= (div_wrap || slow_sys) ? '0 : div_cnt_reg + 1'b1;
			tick_reg    <= !halted && (slow_sys || div_wrap);
		end
	end

	// next mode from halt or wakeup
	sysclk_pkg::op_mode_t mode_next;
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			sysclk_pkg::MODE_FAST, sysclk_pkg::MODE_SLOW: begin
				mode_next = halt_req ? halt_mode : run_mode;
			end
			sysclk_pkg::MODE_SLEEP, sysclk_pkg::MODE_IDLE_SLOW_ONLY,
			sysclk_pkg::MODE_IDLE_BOTH_OSC, sysclk_pkg::MODE_IDLE_FAST_ONLY: begin
				if (wakeup) begin
					mode_next = run_mode;
				end
			end
			default: begin
				mode_next = sysclk_pkg::MODE_FAST;
			end
		endcase
	end

	// mode register, frozen with the clock enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= sysclk_pkg::MODE_FAST;
		end else if (clk_en) begin
			mode_reg <= mode_next;
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	// cpu state, active select and tick, each one flop behind its source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_run           <= 1'b0;
			sysclk_sel_active <= 3'h0;
			sysclk_tick       <= 1'b0;
		end else if (clk_en) begin
			cpu_run           <= !halted;
			sysclk_sel_active <= sel_active_reg;
			sysclk_tick       <= tick_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_osc_on   <= 1'b0;
			fast_freq_sel <= sysclk_pkg::FREQ_8M;
		end else if (clk_en) begin
			fast_osc_on   <= fast_run;
			fast_freq_sel <= fast_freq;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_rc_osc_on <= 1'b0;
			crystal_osc_on <= 1'b0;
		end else if (clk_en) begin
			slow_rc_osc_on <= rc_run;
			crystal_osc_on <= xt_run;
		end
	end

	// drive mode, pins released when crystal unused
	// pins stay gpio through reset so a board without a crystal is safe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crystal_drive_mode <= sysclk_pkg::DRV_LOW_POWER;
			crystal_pins_gpio  <= 1'b1;
		end else if (clk_en) begin
			crystal_drive_mode <= xtal_drv;
			crystal_pins_gpio  <= !xtal_en || pio_req;
		end
	end

	// slow clock to peripherals stops in sleep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_clk_periph_on <= 1'b0;
		end else if (clk_en) begin
			slow_clk_periph_on <= slow_ka_live;
		end
	end

	// 32k users keep running when enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lcd_clk_on      <= 1'b0;
			timebase_clk_on <= 1'b0;
			watchdog_clk_on <= 1'b0;
		end else if (clk_en) begin
			lcd_clk_on      <= lcd_en;
			timebase_clk_on <= tb_en;
			watchdog_clk_on <= wdt_en;
		end
	end
endmodule

//--- dv/sysclk_mode_checker.sv
// timing checks on the clock and mode controller ports
// assumes a single pclk domain with presetn as asynchronous reset
`timescale 1ns/10ps
module sysclk_mode_checker (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       clk_en,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       halt_req,
	input wire logic       wakeup,
	input wire logic       cpu_run,
	input wire logic       fast_osc_on,
	input wire logic [2:0] sysclk_sel_active,
	input wire logic       sysclk_tick
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// bus phases and halt entry as named steps
	sequence s_setup;
		psel && !penable && clk_en;
	endsequence
	sequence s_access;
		psel && penable && clk_en;
	endsequence
	sequence s_halt;
		cpu_run && halt_req && clk_en;
	endsequence

	property p_pready_answer;
		s_setup ##1 s_access |-> pready;
	endproperty
	property p_pready_place;
		pready |-> psel && penable;
	endproperty
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	property p_halt_stop;
		s_halt |-> ##[1:4] !cpu_run;
	endproperty
	property p_wake_run;
		!cpu_run && wakeup && clk_en |-> ##[1:4] cpu_run;
	endproperty
	property p_halted_quiet;
		!cpu_run ##1 !cpu_run |-> !sysclk_tick;
	endproperty
	// a fast-derived select may only land while the fast oscillator runs
	property p_switch_fast;
		$changed(sysclk_sel_active) && sysclk_sel_active != 3'h7 |-> fast_osc_on;
	endproperty
	property p_freeze;
		!clk_en |=> $stable(cpu_run) && $stable(sysclk_sel_active) && $stable(pready);
	endproperty

	a_pready_answer: assert property (p_pready_answer)
		else $error("no ready in access phase");
	a_pready_place: assert property (p_pready_place)
		else $error("ready outside access phase");
	a_err_ready: assert property (p_err_ready)
		else $error("error response without ready");
	a_halt_stop: assert property (p_halt_stop)
		else $error("halt did not stop the cpu");
	a_wake_run: assert property (p_wake_run)
		else $error("wakeup did not restart the cpu");
	a_halted_quiet: assert property (p_halted_quiet)
		else $error("system clock ticks while halted");
	a_switch_fast: assert property (p_switch_fast)
		else $error("switched to fast clock while it was off");
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");
endmodule

bind sysclk_mode_ctrl sysclk_mode_checker u_chk (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .halt_req(halt_req), .wakeup(wakeup),
	.cpu_run(cpu_run), .fast_osc_on(fast_osc_on), .sysclk_sel_active(sysclk_sel_active),
	.sysclk_tick(sysclk_tick)
);

//--- dv/system_clock_mode_control_tb_top.sv
// directed testbench for the clock and mode controller
// assumes apb register map as handed over; crystal counts shortened
`timescale 1ns/10ps
module system_clock_mode_control_tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        clk_en = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        halt_req = 1'b0;
	logic        wakeup = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, cpu_run, fast_osc_on, slow_rc_osc_on, crystal_osc_on;
	logic [1:0]  fast_freq_sel, crystal_drive_mode;
	logic        crystal_pins_gpio, sysclk_tick, slow_clk_periph_on;
	logic [2:0]  sysclk_sel_active;
	logic        lcd_clk_on, timebase_clk_on, watchdog_clk_on;
	logic [31:0] rdv;
	logic        err;
	int          n_errors = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          fv;
	// halt table: keep-alive bits, expected mode, peripheral enables
	logic [1:0]  ka [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
	logic [31:0] md [5] = '{32'h4, 32'h8, 32'h10, 32'h20, 32'h4};
	logic [31:0] per [5] = '{32'h7, 32'h5, 32'h5, 32'h5, 32'h12};

	// 50 MHz bus clock
	always #10 pclk = ~pclk;

	// short crystal counts keep the run brief
	sysclk_mode_ctrl #(.XTAL_QUICK_CYCLES(20), .XTAL_LOWPWR_CYCLES(40), .DIV_WIDTH(6)) DUT (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .halt_req(halt_req), .wakeup(wakeup), .cpu_run(cpu_run),
		.fast_osc_on(fast_osc_on), .fast_freq_sel(fast_freq_sel),
		.slow_rc_osc_on(slow_rc_osc_on), .crystal_osc_on(crystal_osc_on),
		.crystal_drive_mode(crystal_drive_mode), .crystal_pins_gpio(crystal_pins_gpio),
		.sysclk_sel_active(sysclk_sel_active), .sysclk_tick(sysclk_tick),
		.slow_clk_periph_on(slow_clk_periph_on), .lcd_clk_on(lcd_clk_on),
		.timebase_clk_on(timebase_clk_on), .watchdog_clk_on(watchdog_clk_on)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wcyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no local limit: only the bench timeout ends a missing answer
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// extra cycles let registered outputs settle before checks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		wcyc(2);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdv, exp);
	endtask

	// switch waits on stability plus divider wrap, so poll with a bound
	task automatic poll_sel(input logic [2:0] s);
		int n;
		n = 0;
		while (sysclk_sel_active !== s && n < 400) begin
			n++;
			@(posedge pclk);
		end
		chk(32'(sysclk_sel_active), 32'(s));
	endtask

	task automatic pulse(input logic h);
		if (h) begin
			halt_req <= 1'b1;
		end else begin
			wakeup <= 1'b1;
		end
		@(posedge pclk);
		halt_req <= 1'b0;
		wakeup <= 1'b0;
		wcyc(6);
	endtask

	// hang guard, far above the expected run length
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			end_of_test();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		wcyc(20);
		chk(32'(crystal_pins_gpio), 32'h1);
		presetn <= 1'b1;
		wcyc(2);
		chk(32'(fast_osc_on), 32'h1);
		chk(32'(sysclk_sel_active), 32'h0);
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h1);
		wcyc(810);
		rd(8'h04, 32'h3);
		// sweep ends back on the configured 8 MHz setting
		for (int f = 1; f < 4; f++) begin
			fv = f % 3;
			wr(8'h04, 32'((fv << 2) | 1));
			chk(32'(fast_freq_sel), 32'(fv));
			rd(8'h04, 32'((fv << 2) | 1));
			wcyc(810);
			rd(8'h04, 32'((fv << 2) | 3));
		end
		wr(8'h08, 32'h5);
		chk(32'(crystal_osc_on), 32'h1);
		chk(32'(crystal_pins_gpio), 32'h0);
		chk(32'(crystal_drive_mode), 32'h1);
		rd(8'h08, 32'h5);
		wcyc(30);
		rd(8'h08, 32'h7);
		wr(8'h08, 32'h1);
		rd(8'h08, 32'h3);
		wr(8'h00, 32'he4);
		poll_sel(3'h7);
		rd(8'h10, 32'h1c2);
		wr(8'h08, 32'h5);
		rd(8'h08, 32'h3);
		wr(8'h04, 32'h0);
		chk(32'(fast_osc_on), 32'h0);
		wr(8'h04, 32'h1);
		chk(32'(fast_osc_on), 32'h1);
		wcyc(810);
		for (int s = 1; s < 8; s++) begin
			wr(8'h00, 32'(((s % 7) << 5) | 4));
			poll_sel(3'(s % 7));
		end
		for (int i = 0; i < 5; i++) begin
			wr(8'h0c, per[i]);
			wr(8'h00, 32'(ka[i]) | 32'h4);
			pulse(1'b1);
			chk(32'(cpu_run), 32'h0);
			rd(8'h10, md[i]);
			chk(32'(fast_osc_on), 32'(ka[i][1]));
			chk(32'(slow_clk_periph_on), 32'(ka[i][0]));
			if (ka[i] == 2'h0) begin
				chk(32'(lcd_clk_on), 32'(per[i][0]));
				chk(32'(watchdog_clk_on), 32'(per[i][2]));
				chk(32'(slow_rc_osc_on), 32'(per[i][0]));
				chk(32'(timebase_clk_on), 32'(per[i][1]));
				chk(32'(crystal_osc_on), 32'(per[i][1] && per[i][4]));
			end
			pulse(1'b0);
			chk(32'(cpu_run), 32'h1);
		end
		apb(1'b0, 8'h14, 32'h0);
		chk(rdv, 32'h0);
		chk(32'(err), 32'h1);
		clk_en <= 1'b0;
		wcyc(4);
		clk_en <= 1'b1;
		wcyc(2);
		chk(32'(cpu_run), 32'h1);
		end_of_test();
	end
endmodule
